//--- rtl/dosm_pkg.sv
// Constants and types shared by the digital output source multiplexer
package dosm_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCH = 8;
  localparam int NGATE = 6;
  localparam int NSENT = 4;
  localparam int DLY_W = 8;
  localparam int DLY_DEPTH = 256;
  localparam int ARB_IDX_W = 5;
  localparam int ANG_W = 16;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_NS = 8;
  localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Angles: 120, 240 and 180 degrees of a 16-bit turn
  // ----------------------------------------------------------------
  localparam logic [15:0] ANG_120 = 16'h5555;
  localparam logic [15:0] ANG_240 = 16'hAAAA;
  localparam logic [15:0] ANG_180 = 16'h8000;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CHSEL = 8'h00;
  localparam logic [7:0] OFS_DIRECT = 8'h04;
  localparam logic [7:0] OFS_ARB = 8'h08;
  localparam logic [7:0] OFS_POS_RISE = 8'h0C;
  localparam logic [7:0] OFS_POS_FALL = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_DLY0 = 8'h20;
  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_CHSEL = 32'h0000_0000;
  localparam logic [7:0] RST_DIRECT = 8'h00;
  localparam logic [31:0] RST_ARB = 32'h0000_0000;
  localparam logic [15:0] RST_POS_RISE = 16'h0000;
  localparam logic [15:0] RST_POS_FALL = 16'h8000;
  localparam logic [7:0] RST_DLY = 8'h00;
  localparam int CTRL_REDUCED_BIT = 0;
  // ----------------------------------------------------------------
  // Source codes of a channel selector
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SRC_NONE = 4'h0, SRC_MODEL = 4'h1, SRC_DIRECT = 4'h2, SRC_ARB = 4'h3,
    SRC_POS_A = 4'h4, SRC_POS_B = 4'h5, SRC_POS_C = 4'h6, SRC_SENT = 4'h7,
    SRC_GATE0 = 4'h8, SRC_GATE1 = 4'h9, SRC_GATE2 = 4'hA, SRC_GATE3 = 4'hB,
    SRC_GATE4 = 4'hC, SRC_GATE5 = 4'hD
  } dosm_src_type;
endpackage

//--- rtl/dosm_mux.sv
// Digital output source multiplexer with Wishbone register slave
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (RULE1) Each output channel has its own independent source selector.
// (RULE2) Sources: model, direct value, arbitrary pattern, position sensor, SENT, delayed gates.
// (RULE3) Six gate signals are offered as sources, each with its own delay.
// (RULE4) Gate signals are selectable on every channel regardless of other configuration; the code blocks them in the reduced variant.
// (RULE5) Reduced board variant allows only the direct value source.
// (RULE6) Position sensor: three 180 degree pulses shifted by 120, edges configurable.
// (RULE7) SENT output exists only on the first four channels.
// (RULE8) Arbitrary pattern is indexed by motor angle, not by time.
// (RULE9) Direct channel drives the software-written level onto the output.
// (RULE10) Gate inputs are sampled every clock after a two-stage synchroniser.
// (RULE11) Gate inputs 0..5 are U high, U low, V high, V low, W high, W low.
// (RULE12) Switch closed gives output low; switch open gives output high.
// (RULE13) Delayed gate copy is the sampled gate shifted by the set delay.
// (RULE14) After reset or with no source the switch stays open.
module dosm_mux (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [dosm_pkg::NCH-1:0] model_out_i,
  input wire logic [dosm_pkg::ANG_W-1:0] angle_i,
  input wire logic [dosm_pkg::NSENT-1:0] sent_i,
  input wire logic [dosm_pkg::NGATE-1:0] gate_measure_input_i,
  output logic [dosm_pkg::NCH-1:0] fast_low_side_switch_o
);
  import dosm_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Word index match against a byte offset
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] chsel;
  logic [7:0] direct;
  logic [31:0] arb;
  logic [15:0] pos_rise;
  logic [15:0] pos_fall;
  logic reduced;
  logic [DLY_W-1:0] dly [NGATE];
  logic wr;
  logic [31:0] next_dat;
  logic [NGATE-1:0] gsync0;
  logic [NGATE-1:0] gsync;
  logic [DLY_DEPTH-1:0] dline [NGATE];
  logic [NGATE-1:0] gate_dly;
  logic pos_a;
  logic pos_b;
  logic pos_c;
  logic arb_bit;
  logic [NCH-1:0] level;

  // Write lands at the edge where the master samples ack high, never a cycle early
  assign wr = cyc_i && stb_i && we_i && ack_o;

  // Single-cycle ack; dropped the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Register writes; per channel four select bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chsel <= RST_CHSEL;
      direct <= RST_DIRECT;
      arb <= RST_ARB;
      pos_rise <= RST_POS_RISE;
      pos_fall <= RST_POS_FALL;
      reduced <= 1'b0;
    end else if (wr) begin
      if (hit(adr_i, OFS_CHSEL)) chsel <= merge(chsel, dat_i, sel_i); // see (RULE1)
      if (hit(adr_i, OFS_DIRECT) && sel_i[0]) direct <= dat_i[7:0];
      if (hit(adr_i, OFS_ARB)) arb <= merge(arb, dat_i, sel_i);
      if (hit(adr_i, OFS_POS_RISE) && sel_i[0]) pos_rise[7:0] <= dat_i[7:0]; // see (RULE6)
      if (hit(adr_i, OFS_POS_RISE) && sel_i[1]) pos_rise[15:8] <= dat_i[15:8];
      if (hit(adr_i, OFS_POS_FALL) && sel_i[0]) pos_fall[7:0] <= dat_i[7:0]; // see (RULE6)
      if (hit(adr_i, OFS_POS_FALL) && sel_i[1]) pos_fall[15:8] <= dat_i[15:8];
      if (hit(adr_i, OFS_CTRL) && sel_i[0]) reduced <= dat_i[CTRL_REDUCED_BIT];
    end
  end

  // Delay registers, one per gate input
  generate
    for (genvar g = 0; g < NGATE; g++) begin : g_dlyreg
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          dly[g] <= RST_DLY;
        end else if (wr && hit(adr_i, OFS_DLY0 + 8'(4 * g)) && sel_i[0]) begin
          dly[g] <= dat_i[DLY_W-1:0]; // see (RULE3)
        end
      end
    end
  endgenerate

  // Read mux; unmapped addresses read zero but still ack
  always_comb begin
    next_dat = 32'h0000_0000;
    if (hit(adr_i, OFS_CHSEL)) next_dat = chsel;
    if (hit(adr_i, OFS_DIRECT)) next_dat = {24'h00_0000, direct};
    if (hit(adr_i, OFS_ARB)) next_dat = arb;
    if (hit(adr_i, OFS_POS_RISE)) next_dat = {16'h0000, pos_rise};
    if (hit(adr_i, OFS_POS_FALL)) next_dat = {16'h0000, pos_fall};
    if (hit(adr_i, OFS_CTRL)) next_dat = {31'h0000_0000, reduced};
    if (hit(adr_i, OFS_STATUS)) next_dat = {16'h0000, 2'b00, gsync, fast_low_side_switch_o};
    for (int g = 0; g < NGATE; g++) begin
      if (hit(adr_i, OFS_DLY0 + 8'(4 * g))) next_dat = {24'h00_0000, dly[g]};
    end
  end

  // Read data captured with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !ack_o) begin
      dat_o <= next_dat;
    end
  end

  // ----------------------------------------------------------------
  // Gate inputs
  // ----------------------------------------------------------------
  // Pins are asynchronous; two flops before any use, bit order U/V/W high then low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gsync0 <= '0;
      gsync <= '0;
    end else begin
      gsync0 <= gate_measure_input_i; // see (RULE10) (RULE11)
      gsync <= gsync0;
    end
  end

  // Shift lines keep edge order; delay counts whole clock steps
  generate
    for (genvar g = 0; g < NGATE; g++) begin : g_dline
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          dline[g] <= '0;
        end else begin
          dline[g] <= {dline[g][DLY_DEPTH-2:0], gsync[g]}; // see (RULE13)
        end
      end
      assign gate_dly[g] = (dly[g] == '0) ? gsync[g] : dline[g][dly[g] - 8'd1]; // see (RULE13)
    end
  endgenerate

  // ----------------------------------------------------------------
  // Angle based sources
  // ----------------------------------------------------------------
  // Phase window test on the wrapped angle; wrap makes 360 degrees seamless
  function automatic logic in_win(input logic [15:0] ang, input logic [15:0] rise, input logic [15:0] fall);
    logic [15:0] pos;
    logic [15:0] len;
    pos = ang - rise;
    len = fall - rise;
    return pos < len;
  endfunction

  assign pos_a = in_win(angle_i, pos_rise, pos_fall); // see (RULE6)
  assign pos_b = in_win(angle_i - ANG_120, pos_rise, pos_fall); // see (RULE6)
  assign pos_c = in_win(angle_i - ANG_240, pos_rise, pos_fall); // see (RULE6)
  assign arb_bit = arb[angle_i[ANG_W-1 -: ARB_IDX_W]]; // see (RULE8)

  // ----------------------------------------------------------------
  // Per-channel selection
  // ----------------------------------------------------------------
  // Level high means switch open; unknown codes fall back to open
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      level[c] = 1'b1;
      case (dosm_src_type'(chsel[c*4 +: 4])) // see (RULE1) (RULE2)
        SRC_NONE: level[c] = 1'b1; // see (RULE14)
        SRC_MODEL: level[c] = model_out_i[c];
        SRC_DIRECT: level[c] = direct[c]; // see (RULE9)
        SRC_ARB: level[c] = arb_bit;
        SRC_POS_A: level[c] = pos_a;
        SRC_POS_B: level[c] = pos_b;
        SRC_POS_C: level[c] = pos_c;
        SRC_SENT: level[c] = (c < NSENT) ? sent_i[c % NSENT] : 1'b1; // see (RULE7)
        SRC_GATE0: level[c] = gate_dly[0]; // see (RULE4)
        SRC_GATE1: level[c] = gate_dly[1];
        SRC_GATE2: level[c] = gate_dly[2];
        SRC_GATE3: level[c] = gate_dly[3];
        SRC_GATE4: level[c] = gate_dly[4];
        SRC_GATE5: level[c] = gate_dly[5];
        default: level[c] = 1'b1;
      endcase
      if (reduced && chsel[c*4 +: 4] != SRC_DIRECT) begin
        level[c] = 1'b1; // see (RULE5)
      end
    end
  end

  // Switch closed pulls the output low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_low_side_switch_o <= '0; // see (RULE14)
    end else begin
      fast_low_side_switch_o <= ~level; // see (RULE12)
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Reset leaves every switch open
  rst_open_a: assert property (@(posedge clk_i) rst_i |=> fast_low_side_switch_o == '0) // see (RULE14)
    else $error("switch not open after reset");

  // A channel with no source never pulls its output low
  none_open_a: assert property (@(posedge clk_i) disable iff (rst_i)
    chsel[3:0] == SRC_NONE |=> !fast_low_side_switch_o[0]) // see (RULE14)
    else $error("unselected channel switch closed");

  // Direct level reaches the switch one cycle later, inverted
  direct_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    chsel[7:4] == SRC_DIRECT |=> fast_low_side_switch_o[1] == !$past(direct[1])) // see (RULE9)
    else $error("direct level not driven");

  // A direct write holds the low byte that the master carried
  direct_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit(adr_i, OFS_DIRECT) && sel_i[0] |=> direct == $past(dat_i[7:0])) // see (RULE9)
    else $error("direct write lost");

  // Reduced variant blocks every source but the direct value
  reduced_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reduced && chsel[3:0] != SRC_DIRECT |=> !fast_low_side_switch_o[0]) // see (RULE5)
    else $error("reduced variant passed other source");

  // Channels above the fourth have no SENT generator
  sent_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    chsel[19:16] == SRC_SENT |=> !fast_low_side_switch_o[4]) // see (RULE7)
    else $error("SENT on channel four");

  // Lower channels pass their SENT level through
  sent_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    chsel[15:12] == SRC_SENT && !reduced |=> fast_low_side_switch_o[3] == !$past(sent_i[3])) // see (RULE7)
    else $error("SENT level not passed");

  // Model level passes through when the variant allows it
  model_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    chsel[23:20] == SRC_MODEL && !reduced |=> fast_low_side_switch_o[5] == !$past(model_out_i[5])) // see (RULE2)
    else $error("model level not passed");

  // Pattern bit follows the top angle bits
  arb_angle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    chsel[15:12] == SRC_ARB && !reduced |=> fast_low_side_switch_o[3] == !$past(arb[angle_i[15:11]])) // see (RULE8)
    else $error("pattern not indexed by angle");

  // Half-turn pulses shifted by a third never agree on all three phases
  pos_spread_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pos_fall - pos_rise == ANG_180 |-> !(pos_a == pos_b && pos_b == pos_c)) // see (RULE6)
    else $error("sensor phases not spread");

  // Undelayed gate copy is the synchronised pin one cycle later
  gate_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
    chsel[31:28] == SRC_GATE5 && !reduced && dly[5] == '0 ##1 chsel[31:28] == SRC_GATE5
    |-> fast_low_side_switch_o[7] == !$past(gsync[5])) // see (RULE4) (RULE13)
    else $error("gate copy wrong");

  // A delay of seven adds exactly seven steps to the gate path
  gate_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    chsel[3:0] == SRC_GATE0 && !reduced && dly[0] == 8'd7
    |=> fast_low_side_switch_o[0] == !$past(gsync[0], 8)) // see (RULE3) (RULE13)
    else $error("gate delay wrong");

  // Ack is a single-cycle pulse
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o)
    else $error("ack held two cycles");
endmodule // dosm_mux
`default_nettype wire

//--- dv/dosm_ecu_model.sv
// Behavioural model of the controller unit that drives gate pins and sees outputs
`timescale 1ns/1ps
`default_nettype none
module dosm_ecu_model (
  input wire logic clk_i,
  input wire logic [5:0] gate_cmd_i,
  input wire logic [7:0] switch_i,
  output logic [5:0] gate_o,
  output logic [7:0] pin_level_o
);
  // Gate drives change just after an edge, in the order U hi, U lo, V hi, V lo, W hi, W lo
  always_ff @(posedge clk_i) begin
    gate_o <= gate_cmd_i;
  end
  // The pull-up holds the pin high unless the switch is closed
  assign pin_level_o = ~switch_i;
endmodule // dosm_ecu_model
`default_nettype wire

//--- dv/dosm_mux_bench.sv
// Self-checking bench for the digital output source multiplexer
`timescale 1ns/1ps
`default_nettype none
module dosm_mux_bench;
  import dosm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, dat_o, q;
  logic ack_o;
  logic [7:0] model = 8'h00, sw, pin;
  logic [15:0] angle = 16'h0000;
  logic [3:0] sent = 4'h0;
  logic [5:0] gate_cmd = 6'h00, gate;
  int miscompares = 0, n_checks = 0, cycles = 0, n0, n7;
  // ----------------------------------------------------------------
  // Design, far side and clock
  // ----------------------------------------------------------------
  dosm_mux i_dosm_mux (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .model_out_i(model), .angle_i(angle),
    .sent_i(sent), .gate_measure_input_i(gate), .fast_low_side_switch_o(sw));
  dosm_ecu_model i_dosm_ecu_model (.clk_i(clk_i), .gate_cmd_i(gate_cmd), .switch_i(sw), .gate_o(gate),
    .pin_level_o(pin));
  // Free-running clock
  always #5 clk_i = ~clk_i;
  // Watchdog: a hang counts as a mismatch
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic single cycle; held until ack is sampled, released at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  // Long enough for sync, a delay of 7 and the output stage
  task automatic settle();
    repeat (12) @(posedge clk_i);
  endtask
  // Raise gate 0 and count edges until channel 0 opens its switch; a lost edge fails here
  task automatic meas(output int n);
    gate_cmd <= 6'h01;
    n = 0;
    do begin @(posedge clk_i); n++; end while (sw[0] !== 1'b0 && n < 300);
    chk(sw[0], 1'b0);
    gate_cmd <= 6'h00;
    settle();
  endtask
  task automatic end_sim();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    chk(sw, 8'h00);
    wb(0, OFS_CHSEL, 0, 4'hF); chk(q, RST_CHSEL);
    wb(0, OFS_POS_FALL, 0, 4'hF); chk(q, 32'h0000_8000);
    wb(1, 8'h40, 32'hFFFF_FFFF, 4'hF); wb(0, 8'h40, 0, 4'hF); chk(q, 0); // unmapped place
    // Mixed sources, one per channel
    angle <= 16'h2000; model <= 8'h20; sent <= 4'hF; gate_cmd <= 6'h20;
    wb(1, OFS_ARB, 32'h0000_0010, 4'hF);
    wb(1, OFS_CHSEL, 32'hD217_3654, 4'hF);
    settle();
    chk(sw, 8'h42);
    wb(0, OFS_STATUS, 0, 4'hF); chk(q[7:0], 8'h42);
    angle <= 16'h2800; settle(); chk(sw[3], 1'b1);
    // Position edges moved
    angle <= 16'h2000;
    wb(1, OFS_POS_RISE, 32'h0000_1000, 4'hF); wb(1, OFS_POS_FALL, 32'h0000_3000, 4'hF);
    settle(); chk(sw[2:0], 3'b110);
    // SENT on channel 3, direct write blocked by byte enable
    sent <= 4'h7; wb(1, OFS_DIRECT, 32'h0000_00FF, 4'hE);
    wb(1, OFS_CHSEL, 32'h0000_7000, 4'hF); settle(); chk(sw, 8'h08);
    // Each gate on its own channel
    gate_cmd <= 6'b010110; wb(1, OFS_CHSEL, 32'h00DC_BA98, 4'hF);
    settle(); chk(sw, 8'h29);
    // Reduced variant lets only direct values through
    model <= 8'hFF; wb(1, OFS_CTRL, 1, 4'hF); wb(1, OFS_DIRECT, 32'h0000_000F, 4'hF);
    wb(1, OFS_CHSEL, 32'h2222_2221, 4'hF); settle(); chk(sw, 8'hF0);
    chk(pin, 8'h0F);
    wb(1, OFS_CTRL, 0, 4'hF); gate_cmd <= 6'h00;
    // Delay adds exactly its count of steps
    wb(1, OFS_CHSEL, 32'h0000_0008, 4'hF); settle(); meas(n0);
    wb(1, OFS_DLY0, 7, 4'hF); settle(); meas(n7);
    chk(n7 - n0, 7);
    end_sim();
  end
endmodule // dosm_mux_bench
`default_nettype wire
